// ===== gpio_pkg.sv
// constants for the parallel i/o port block
package gpio_pkg;

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [5:0] PORT0_LATCH_OFS = 6'h00;
   localparam logic [5:0] PORT1_LATCH_OFS = 6'h01;
   localparam logic [5:0] PORT2_LATCH_OFS = 6'h02;
   localparam logic [5:0] PORT3_LATCH_OFS = 6'h03;
   localparam logic [5:0] PORT4_LATCH_OFS = 6'h04;
   localparam logic [5:0] PORT0_PIN_OFS = 6'h08;
   localparam logic [5:0] PORT2_PIN_OFS = 6'h0A;
   localparam logic [5:0] PORT1_DIR_OFS = 6'h0D;
   localparam logic [5:0] PORT3_DIR_OFS = 6'h0E;
   localparam logic [5:0] PORT4_DIR_OFS = 6'h0F;
   localparam logic [5:0] CONV_CTL1_OFS = 6'h1C;
   localparam logic [5:0] EXT_IRQ_CTL_OFS = 6'h37;

   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [7:0] PORT0_LATCH_RST = 8'hFF;
   localparam logic [7:0] PORT1_LATCH_RST = 8'h00;
   localparam logic [2:0] PORT2_LATCH_RST = 3'h7;
   localparam logic [7:0] PORT3_LATCH_RST = 8'h00;
   localparam logic [7:0] PORT4_LATCH_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] CONV_CTL1_RST = 8'h10;
   localparam logic [7:0] EXT_IRQ_CTL_RST = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int AIN_DISABLE_BIT = 4;
   localparam int CHAN_SEL_LSB = 0;
   localparam int CHAN_SEL_W = 3;
   localparam int IRQ0_SEL_BIT = 6;
   localparam int PORT2_W = 3;
   localparam logic [7:0] EXT_IRQ_CTL_MASK = 8'hFE;

endpackage

// ===== parallel_io_ports.sv
// five parallel i/o ports with their latches, direction registers on ports 1, 3 and 4, and pin reads
//
// Summary of operation
// (R01) each bit has an output latch; pin reads return the current level
// (R02) a port read samples the pins in the read strobe cycle
// (R03) a port write changes the driven value in the following cycle
// (R04) reset sets all eight port 0 latch bits to one
// (R05) port 0 latch read/write at one address, pins read-only at another
// (R06) port 0 bit 0 is i/o or interrupt 0 input; input after reset
// (R07) software sets port 0 or 2 latch bits to one for input use
// (R08) port 1 bit is input when direction bit zero, output when one
// (R09) reset clears port 1 direction and latches; all pins inputs
// (R10) software sets latch then direction for port 1 output functions
// (R11) latch writes on ports 1, 3, 4 accepted whatever the direction
// (R12) ports 1, 3, 4 read pins for inputs and latches for outputs
// (R13) port 2 is three bits wide, latch set to one on reset
// (R14) dual-clock mode gives port 2 bits 1 and 2 to the crystal
// (R15) port 2 bit 0 falling edge flags interrupt even when driven
// (R16) port 2 has latch and pin read addresses; upper bits undefined
// (R17) reset clears port 3 direction and sets the analog disable bit
// (R18) analog disable low makes the selected port 3 pin analog
// (R19) the selected analog bit reads zero; others read pin or latch by direction
// (R20) software avoids port 3 writes and noisy neighbours in conversion
// (R21) port 4 direction selects input or output; reset clears all
// (R22) pin-select zero keeps port 0 bit 0 i/o, one routes interrupt 0
// (R23) port 2 ignores writes above bit 2; updates on the system clock
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module parallel_io_ports
#(
   parameter int PORT_W = 8,
   parameter int NARROW_PORT_W = 3
)
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [5:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic dual_clock_mode_i,
   input wire logic [7:0] port0_pin_i,
   output logic [7:0] port0_pin_o,
   output logic [7:0] port0_oe_o,
   input wire logic [7:0] port1_pin_i,
   output logic [7:0] port1_pin_o,
   output logic [7:0] port1_oe_o,
   input wire logic [2:0] port2_pin_i,
   output logic [2:0] port2_pin_o,
   output logic [2:0] port2_oe_o,
   input wire logic [7:0] port3_pin_i,
   output logic [7:0] port3_pin_o,
   output logic [7:0] port3_oe_o,
   input wire logic [7:0] port4_pin_i,
   output logic [7:0] port4_pin_o,
   output logic [7:0] port4_oe_o,
   output logic external_irq_zero_o,
   output logic irq0_fall_o,
   output logic port2_bit0_fall_o,
   output logic analog_enable_o,
   output logic [2:0] analog_channel_select_o
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0] port0_latch_reg;
   logic [7:0] port1_latch_reg;
   logic [2:0] port2_latch_reg;
   logic [7:0] port3_latch_reg;
   logic [7:0] port4_latch_reg;
   logic [7:0] port1_direction_reg;
   logic [7:0] port3_direction_reg;
   logic [7:0] port4_direction_reg;
   logic [7:0] conv_ctl1_reg;
   logic [7:0] ext_irq_ctl_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [34:0] meta_reg;
   logic [34:0] sync_reg;
   logic irq0_prev_reg;
   logic p2b0_prev_reg;
   logic irq0_fall_reg;
   logic p2b0_fall_reg;
   logic [7:0] p0_sync;
   logic [7:0] p1_sync;
   logic [2:0] p2_sync;
   logic [7:0] p3_sync;
   logic [7:0] p4_sync;
   logic wr_en;
   logic analog_disable;
   logic irq0_pin_select;
   logic [7:0] analog_mask;
   logic [7:0] p1_read;
   logic [7:0] p3_read;
   logic [7:0] p4_read;
   logic [2:0] crystal_mask;

   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   if (PORT_W != 8 || NARROW_PORT_W != gpio_pkg::PORT2_W)
   begin : g_width_check
      $error("port widths other than 8 and 3 bits are not supported");
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= 35'h0;
         sync_reg <= 35'h0;
      end
      else if (ce_i)
      begin
         meta_reg <= {port4_pin_i, port3_pin_i, port2_pin_i, port1_pin_i, port0_pin_i};
         sync_reg <= meta_reg;
      end
   end

   assign p0_sync = sync_reg[7:0];
   assign p1_sync = sync_reg[15:8];
   assign p2_sync = sync_reg[18:16];
   assign p3_sync = sync_reg[26:19];
   assign p4_sync = sync_reg[34:27];

   assign wr_en = ce_i & wr_i;
   assign analog_disable = conv_ctl1_reg[gpio_pkg::AIN_DISABLE_BIT];
   assign irq0_pin_select = ext_irq_ctl_reg[gpio_pkg::IRQ0_SEL_BIT];

   // ----------------------------------------
   // port 0 latch
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port0_latch_reg <= gpio_pkg::PORT0_LATCH_RST; // see (R04)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT0_LATCH_OFS) // see (R05)
      begin
         port0_latch_reg <= wdata_i; // see (R01) see (R03)
      end
   end

   // ----------------------------------------
   // port 1 latch and direction
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port1_latch_reg <= gpio_pkg::PORT1_LATCH_RST; // see (R09)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT1_LATCH_OFS)
      begin
         port1_latch_reg <= wdata_i; // see (R11)
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port1_direction_reg <= gpio_pkg::DIR_RST; // see (R09)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT1_DIR_OFS)
      begin
         port1_direction_reg <= wdata_i; // see (R08)
      end
   end

   // ----------------------------------------
   // port 2 latch
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port2_latch_reg <= gpio_pkg::PORT2_LATCH_RST; // see (R13)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT2_LATCH_OFS)
      begin
         port2_latch_reg <= wdata_i[2:0]; // see (R23)
      end
   end

   // ----------------------------------------
   // port 3 latch and direction
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port3_latch_reg <= gpio_pkg::PORT3_LATCH_RST;
      end
      else if (wr_en && addr_i == gpio_pkg::PORT3_LATCH_OFS)
      begin
         port3_latch_reg <= wdata_i; // see (R11)
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port3_direction_reg <= gpio_pkg::DIR_RST; // see (R17)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT3_DIR_OFS)
      begin
         port3_direction_reg <= wdata_i;
      end
   end

   // ----------------------------------------
   // port 4 latch and direction
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port4_latch_reg <= gpio_pkg::PORT4_LATCH_RST; // see (R21)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT4_LATCH_OFS)
      begin
         port4_latch_reg <= wdata_i; // see (R11)
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         port4_direction_reg <= gpio_pkg::DIR_RST; // see (R21)
      end
      else if (wr_en && addr_i == gpio_pkg::PORT4_DIR_OFS)
      begin
         port4_direction_reg <= wdata_i;
      end
   end

   // ----------------------------------------
   // converter and interrupt control
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         conv_ctl1_reg <= gpio_pkg::CONV_CTL1_RST; // see (R17)
      end
      else if (wr_en && addr_i == gpio_pkg::CONV_CTL1_OFS)
      begin
         conv_ctl1_reg <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         ext_irq_ctl_reg <= gpio_pkg::EXT_IRQ_CTL_RST; // see (R06)
      end
      else if (wr_en && addr_i == gpio_pkg::EXT_IRQ_CTL_OFS)
      begin
         ext_irq_ctl_reg <= wdata_i & gpio_pkg::EXT_IRQ_CTL_MASK;
      end
   end

   // ----------------------------------------
   // mixed pin/latch read values
   // ----------------------------------------
   always_comb
   begin
      analog_mask = 8'h00;
      if (!analog_disable)
      begin
         analog_mask[conv_ctl1_reg[2:0]] = 1'b1; // see (R18)
      end
   end

   assign p1_read = (port1_direction_reg & port1_latch_reg)
                  | (~port1_direction_reg & p1_sync); // see (R12)
   assign p3_read = ((port3_direction_reg & port3_latch_reg)
                  | (~port3_direction_reg & p3_sync)) & ~analog_mask; // see (R19)
   assign p4_read = (port4_direction_reg & port4_latch_reg)
                  | (~port4_direction_reg & p4_sync); // see (R12)

   // ----------------------------------------
   // read decode
   // ----------------------------------------
   always_comb
   begin
      case (addr_i)
         gpio_pkg::PORT0_LATCH_OFS: rdata_next = port0_latch_reg;
         gpio_pkg::PORT1_LATCH_OFS: rdata_next = p1_read;
         gpio_pkg::PORT2_LATCH_OFS: rdata_next = {5'h00, port2_latch_reg}; // see (R16)
         gpio_pkg::PORT3_LATCH_OFS: rdata_next = p3_read;
         gpio_pkg::PORT4_LATCH_OFS: rdata_next = p4_read;
         gpio_pkg::PORT0_PIN_OFS: rdata_next = p0_sync; // see (R05)
         gpio_pkg::PORT2_PIN_OFS: rdata_next = {5'h00, p2_sync}; // see (R16)
         gpio_pkg::PORT1_DIR_OFS: rdata_next = port1_direction_reg;
         gpio_pkg::PORT3_DIR_OFS: rdata_next = port3_direction_reg;
         gpio_pkg::PORT4_DIR_OFS: rdata_next = port4_direction_reg;
         gpio_pkg::CONV_CTL1_OFS: rdata_next = conv_ctl1_reg;
         gpio_pkg::EXT_IRQ_CTL_OFS: rdata_next = ext_irq_ctl_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // synchronised pin levels are sampled in the strobe cycle, data stands in the next
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         rdata_reg <= 8'h00;
      end
      else if (ce_i)
      begin
         rdata_reg <= rd_i ? rdata_next : 8'h00; // see (R02) see (R01)
      end
   end

   assign rdata_o = rdata_reg;

   // ----------------------------------------
   // interrupt edge detection
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         irq0_prev_reg <= 1'b0;
         p2b0_prev_reg <= 1'b0;
         irq0_fall_reg <= 1'b0;
         p2b0_fall_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         irq0_prev_reg <= p0_sync[0];
         p2b0_prev_reg <= p2_sync[0];
         irq0_fall_reg <= irq0_pin_select & irq0_prev_reg & ~p0_sync[0]; // see (R22)
         p2b0_fall_reg <= p2b0_prev_reg & ~p2_sync[0]; // see (R15)
      end
   end

   assign irq0_fall_o = irq0_fall_reg;
   assign port2_bit0_fall_o = p2b0_fall_reg;
   assign external_irq_zero_o = irq0_pin_select & p0_sync[0]; // see (R06)

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   assign crystal_mask = dual_clock_mode_i ? 3'h6 : 3'h0; // see (R14)

   assign port0_pin_o = port0_latch_reg;
   assign port0_oe_o = ~port0_latch_reg & {7'h7F, ~irq0_pin_select}; // see (R22)
   assign port1_pin_o = port1_latch_reg;
   assign port1_oe_o = port1_direction_reg; // see (R08)
   assign port2_pin_o = port2_latch_reg;
   assign port2_oe_o = ~port2_latch_reg & ~crystal_mask; // see (R14)
   assign port3_pin_o = port3_latch_reg;
   assign port3_oe_o = port3_direction_reg & ~analog_mask; // see (R18)
   assign port4_pin_o = port4_latch_reg;
   assign port4_oe_o = port4_direction_reg; // see (R21)

   assign analog_enable_o = ~analog_disable;
   assign analog_channel_select_o = conv_ctl1_reg[2:0];

endmodule

`default_nettype wire

// ===== pio_chk.sv
// assertions on the ports of the parallel i/o port block
`timescale 1ns/1ps
`default_nettype none
module pio_chk
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [5:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic dual_clock_mode_i,
   input wire logic [7:0] port0_pin_o,
   input wire logic [7:0] port0_oe_o,
   input wire logic [7:0] port1_pin_o,
   input wire logic [7:0] port1_oe_o,
   input wire logic [2:0] port2_pin_o,
   input wire logic [2:0] port2_oe_o,
   input wire logic [7:0] port3_oe_o,
   input wire logic [7:0] port4_pin_o,
   input wire logic [7:0] port4_oe_o,
   input wire logic analog_enable_o,
   input wire logic [2:0] analog_channel_select_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   property p_rst;
      !resetn_i |=> port0_pin_o == 8'hFF && port1_oe_o == 8'h00 && port2_pin_o == 3'h7
         && port3_oe_o == 8'h00 && port4_pin_o == 8'h00 && !analog_enable_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_idle;
      disable iff (!resetn_i) (ce_i && !rd_i) |=> rdata_o == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("read data without read");
   property p_wr1;
      disable iff (!resetn_i)
      (ce_i && wr_i && addr_i == gpio_pkg::PORT1_LATCH_OFS) |=> port1_pin_o == $past(wdata_i);
   endproperty
   a_wr1: assert property (p_wr1) else $error("port 1 write late");
   property p_wr4;
      disable iff (!resetn_i)
      (ce_i && wr_i && addr_i == gpio_pkg::PORT4_LATCH_OFS) |=> port4_pin_o == $past(wdata_i);
   endproperty
   a_wr4: assert property (p_wr4) else $error("port 4 write lost");
   property p_wr2;
      disable iff (!resetn_i) (ce_i && wr_i && addr_i == gpio_pkg::PORT2_LATCH_OFS)
         |=> {5'h00, port2_pin_o} == ($past(wdata_i) & 8'h07);
   endproperty
   a_wr2: assert property (p_wr2) else $error("port 2 write wrong");
   property p_dir1;
      disable iff (!resetn_i)
      (ce_i && wr_i && addr_i == gpio_pkg::PORT1_DIR_OFS) |=> port1_oe_o == $past(wdata_i);
   endproperty
   a_dir1: assert property (p_dir1) else $error("port 1 direction wrong");
   property p_hold;
      disable iff (!resetn_i) (ce_i && !wr_i) |=> $stable(port1_pin_o) && $stable(port4_oe_o);
   endproperty
   a_hold: assert property (p_hold) else $error("latch moved without write");
   property p_ce;
      disable iff (!resetn_i) !ce_i |=> $stable(port4_pin_o) && $stable(port0_pin_o);
   endproperty
   a_ce: assert property (p_ce) else $error("state moved with enable low");
   property p_od;
      disable iff (!resetn_i) port0_oe_o[7:1] == ~port0_pin_o[7:1];
   endproperty
   a_od: assert property (p_od) else $error("port 0 drive wrong");
   property p_dual;
      disable iff (!resetn_i) dual_clock_mode_i |-> port2_oe_o[2:1] == 2'b00;
   endproperty
   a_dual: assert property (p_dual) else $error("crystal pins driven");
   property p_ain;
      disable iff (!resetn_i) analog_enable_o |-> !port3_oe_o[analog_channel_select_o];
   endproperty
   a_ain: assert property (p_ain) else $error("analog pin driven");
endmodule
`default_nettype wire

// ===== pio_pin_model.sv
// outside world at the pins: resolves each pin level
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model
#(
   parameter int W = 8
)
(
   input wire logic [W-1:0] drv_i,
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] ext_i,
   output logic [W-1:0] lvl_o
);
   // driven bits show the block's value, released bits the outside level
   assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ===== parallel_io_ports_tb_top.sv
// self-checking bench for the parallel i/o port block
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_tb_top;
   typedef struct packed
   {
      logic [5:0] la;
      logic [5:0] da;
      logic [7:0] lat;
      logic [7:0] dir;
      logic [7:0] pin;
      logic [7:0] exp;
   } row_t;
   row_t rows [0:3] = '{'{6'h01, 6'h0D, 8'hA5, 8'hF0, 8'h3C, 8'hAC},
      '{6'h03, 6'h0E, 8'h5A, 8'h0F, 8'hC3, 8'hCA}, '{6'h04, 6'h0F, 8'h33, 8'hFF, 8'hCC, 8'h33},
      '{6'h04, 6'h0F, 8'hFF, 8'h00, 8'h96, 8'h96}};
   logic core_clk_i, resetn_i, ce_i, wr_i, rd_i, dual_clock_mode_i;
   logic [5:0] addr_i;
   logic [7:0] wdata_i, rdata_o, ext0, ext1, ext3, ext4;
   logic [2:0] ext2, port2_pin_i, port2_pin_o, port2_oe_o, analog_channel_select_o;
   logic [7:0] port0_pin_i, port0_pin_o, port0_oe_o, port1_pin_i, port1_pin_o, port1_oe_o;
   logic [7:0] port3_pin_i, port3_pin_o, port3_oe_o, port4_pin_i, port4_pin_o, port4_oe_o;
   logic external_irq_zero_o, irq0_fall_o, port2_bit0_fall_o, analog_enable_o;
   int err_total = 0;
   int total_checks = 0;
   parallel_io_ports dut_u (.core_clk_i, .resetn_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .dual_clock_mode_i, .port0_pin_i, .port0_pin_o, .port0_oe_o, .port1_pin_i,
      .port1_pin_o, .port1_oe_o, .port2_pin_i, .port2_pin_o, .port2_oe_o, .port3_pin_i,
      .port3_pin_o, .port3_oe_o, .port4_pin_i, .port4_pin_o, .port4_oe_o, .external_irq_zero_o,
      .irq0_fall_o, .port2_bit0_fall_o, .analog_enable_o, .analog_channel_select_o);
   pio_pin_model #(.W(8)) m0 (.drv_i(port0_pin_o), .oe_i(port0_oe_o), .ext_i(ext0), .lvl_o(port0_pin_i));
   pio_pin_model #(.W(8)) m1 (.drv_i(port1_pin_o), .oe_i(port1_oe_o), .ext_i(ext1), .lvl_o(port1_pin_i));
   pio_pin_model #(.W(3)) m2 (.drv_i(port2_pin_o), .oe_i(port2_oe_o), .ext_i(ext2), .lvl_o(port2_pin_i));
   pio_pin_model #(.W(8)) m3 (.drv_i(port3_pin_o), .oe_i(port3_oe_o), .ext_i(ext3), .lvl_o(port3_pin_i));
   pio_pin_model #(.W(8)) m4 (.drv_i(port4_pin_o), .oe_i(port4_oe_o), .ext_i(ext4), .lvl_o(port4_pin_i));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(negedge core_clk_i);
   endtask
   task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk(nm, e, rdata_o);
   endtask
   task automatic pulse(input string nm, input logic sel);
      logic hit;
      hit = 1'b0;
      repeat (8)
      begin
         @(negedge core_clk_i);
         if ((sel ? port2_bit0_fall_o : irq0_fall_o) === 1'b1)
            hit = 1'b1;
      end
      chk(nm, 8'h01, {7'h00, hit});
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   initial
   begin
      repeat (100000) @(posedge core_clk_i);
      err_total++;
      give_verdict();
   end
   initial
   begin
      {resetn_i, wr_i, rd_i, dual_clock_mode_i, addr_i, wdata_i} = '0;
      {ce_i, ext0, ext1, ext2, ext3, ext4} = {1'b1, 8'hFF, 8'h00, 3'h7, 16'h0000};
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      foreach (rows[k])
      begin
         @(posedge core_clk_i);
         {ext1, ext3, ext4} <= {3{rows[k].pin}};
         wr(rows[k].la, rows[k].lat);
         wr(rows[k].da, rows[k].dir);
         repeat (2) @(posedge core_clk_i);
         rdc("mixed read", rows[k].la, rows[k].exp);
      end
      // port 0: latch and pin levels at separate places
      wr(6'h00, 8'h5A);
      chk("p0 drive", 8'h5A, port0_pin_o);
      repeat (2) @(posedge core_clk_i);
      rdc("p0 pins", 6'h08, 8'h5A);
      wr(6'h08, 8'h00);
      rdc("p0 latch", 6'h00, 8'h5A);
      // interrupt 0 input on port 0 bit 0, latch released first
      wr(6'h00, 8'hFF);
      wr(6'h37, 8'h40);
      chk("p0 oe", 8'h00, port0_oe_o);
      chk("irq0 level high", 8'h01, {7'h00, external_irq_zero_o});
      @(posedge core_clk_i);
      ext0 <= 8'hFE;
      pulse("irq0 fall", 1'b0);
      chk("irq0 level", 8'h00, {7'h00, external_irq_zero_o});
      rdc("irq ctl", 6'h37, 8'h40);
      // port 2: three bits, separate reads, falling edge on a driven bit
      wr(6'h02, 8'hFA);
      chk("p2 out", 8'h02, {5'h00, port2_pin_o});
      repeat (2) @(posedge core_clk_i);
      rdc("p2 latch", 6'h02, 8'h02);
      rdc("p2 pins", 6'h0A, 8'h02);
      wr(6'h02, 8'h07);
      repeat (3) @(posedge core_clk_i);
      wr(6'h02, 8'h06);
      pulse("p2 fall", 1'b1);
      wr(6'h02, 8'h00);
      @(posedge core_clk_i);
      dual_clock_mode_i <= 1'b1;
      @(negedge core_clk_i);
      chk("p2 oe dual", 8'h01, {5'h00, port2_oe_o});
      @(posedge core_clk_i);
      dual_clock_mode_i <= 1'b0;
      // analog channel 3; latch and direction set before conversion
      wr(6'h03, 8'hFF);
      wr(6'h0E, 8'hFF);
      wr(6'h1C, 8'h03);
      chk("p3 oe", 8'hF7, port3_oe_o);
      chk("p3 drive", 8'hFF, port3_pin_o);
      rdc("p3 read", 6'h03, 8'hF7);
      // write with the clock enable low is lost
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      wr(6'h04, 8'h77);
      chk("ce hold", 8'hFF, port4_pin_o);
      @(posedge core_clk_i);
      ce_i <= 1'b1;
      // second reset in mid-run
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(negedge core_clk_i);
      chk("p0 oe rst", 8'h00, port0_oe_o);
      chk("p1 oe rst", 8'h00, port1_oe_o);
      rdc("p0 rst", 6'h00, 8'hFF);
      rdc("p1 dir rst", 6'h0D, 8'h00);
      rdc("p2 rst", 6'h02, 8'h07);
      rdc("p3 dir rst", 6'h0E, 8'h00);
      rdc("conv rst", 6'h1C, 8'h10);
      rdc("p4 dir rst", 6'h0F, 8'h00);
      rdc("p4 pins rst", 6'h04, 8'h96);
      chk("p4 rst", 8'h00, port4_pin_o);
      give_verdict();
   end
endmodule
bind parallel_io_ports pio_chk chk_u (.core_clk_i, .resetn_i, .ce_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .dual_clock_mode_i, .port0_pin_o, .port0_oe_o, .port1_pin_o, .port1_oe_o,
   .port2_pin_o, .port2_oe_o, .port3_oe_o, .port4_pin_o, .port4_oe_o, .analog_enable_o,
   .analog_channel_select_o);
`default_nettype wire
